// ==== pkg/byte_op_regs.svh ====
// Encodings, field positions and reset values for the instruction subset
`ifndef BYTE_OP_REGS_SVH
`define BYTE_OP_REGS_SVH

// ----------------------------------------------------------------
// Instruction word fields (14-bit word)
// ----------------------------------------------------------------
`define OPW_WIDTH        14
`define OP_FILE_HI       13
`define OP_FILE_LO       8
`define OP_LIT_HI        13
`define OP_LIT_LO        8
`define OP_BR_HI         13
`define OP_BR_LO         11
`define DEST_BIT         7
`define FADDR_HI         6
`define FADDR_LO         0
`define LIT_HI           7
`define LIT_LO           0
`define BR_K_HI          10
`define BR_K_LO          0
`define LATCH_HI         6
`define LATCH_LO         3

// ----------------------------------------------------------------
// Opcode values
// ----------------------------------------------------------------
`define OPC_DECSKIP      6'h0b
`define OPC_INCSKIP      6'h0f
`define OPC_INCREMENT_FILE         6'h0a
`define OPC_ORWF         6'h04
`define OPC_ORLIT        6'h38
`define OPC_BRANCH       3'h5

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ACC_RESET        8'h00
`define PC_RESET         15'h0000

`endif

// ==== pkg/byte_op_pkg.sv ====
// Types shared by the instruction subset executor
package byte_op_pkg;

  typedef enum logic [2:0] {
    OP_NONE    = 3'h0,
    OP_DECSKIP = 3'h1,
    OP_INCSKIP = 3'h2,
    OP_INCREMENT_FILE    = 3'h3,
    OP_ORWF    = 3'h4,
    OP_ORLIT   = 3'h5,
    OP_BRANCH  = 3'h6
  } op_kind_t;

  typedef enum logic [1:0] {
    ST_EXEC    = 2'b00,
    ST_FLUSH   = 2'b01,
    ST_BR_WAIT = 2'b10
  } exec_state_t;

endpackage : byte_op_pkg

// ==== pkg/decode_if.sv ====
// Decoded instruction fields passed from decoder to executor
`timescale 1ns/100ps
`default_nettype none
interface decode_if;
  byte_op_pkg::op_kind_t kind;
  logic                  destFile;
  logic [6:0]            fileAddr;
  logic [7:0]            literal;
  logic [10:0]           branchTarget;

  modport dec (output kind, output destFile, output fileAddr, output literal,
               output branchTarget);
  modport exe (input kind, input destFile, input fileAddr, input literal,
               input branchTarget);
endinterface : decode_if
`default_nettype wire

// ==== rtl/byte_op_decoder.sv ====
// Combinational decoder of the supported instruction words
`timescale 1ns/100ps
`default_nettype none
`include "byte_op_regs.svh"
module byte_op_decoder (
  input  wire logic [`OPW_WIDTH-1:0] instr,
  decode_if.dec                      dec
);
  always_comb begin
    dec.destFile     = instr[`DEST_BIT];
    dec.fileAddr     = instr[`FADDR_HI:`FADDR_LO];
    dec.literal      = instr[`LIT_HI:`LIT_LO];
    dec.branchTarget = instr[`BR_K_HI:`BR_K_LO];
    dec.kind         = byte_op_pkg::OP_NONE;
    if (instr[`OP_BR_HI:`OP_BR_LO] == `OPC_BRANCH) begin
      dec.kind = byte_op_pkg::OP_BRANCH;
    end else begin
      case (instr[`OP_FILE_HI:`OP_FILE_LO])
        `OPC_DECSKIP: dec.kind = byte_op_pkg::OP_DECSKIP;
        `OPC_INCSKIP: dec.kind = byte_op_pkg::OP_INCSKIP;
        `OPC_INCREMENT_FILE:    dec.kind = byte_op_pkg::OP_INCREMENT_FILE;
        `OPC_ORWF:    dec.kind = byte_op_pkg::OP_ORWF;
        `OPC_ORLIT:   dec.kind = byte_op_pkg::OP_ORLIT;
        default:      dec.kind = byte_op_pkg::OP_NONE;
      endcase
    end
  end
endmodule : byte_op_decoder
`default_nettype wire

// ==== rtl/byte_op_branch_exec.sv ====
// Executor for skip, increment, OR and branch instructions
//
// Function
// - Destination bit: 0 accumulator, 1 file
// - Decrement-skip subtracts one, flags untouched
// - Decrement-skip zero result flushes next instruction
// - Increment-skip adds one, zero flushes next
// - Branch loads immediate into PC[10:0]
// - Branch fills PC[14:11] from latch[6:3]
// - Branch always takes two cycles
// - OR literal into accumulator, zero updated
// - Increment file, zero updated, no skip
// - OR accumulator with file, zero updated
`timescale 1ns/100ps
`default_nettype none
`include "byte_op_regs.svh"
module byte_op_branch_exec (
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  input  wire logic [`OPW_WIDTH-1:0] instr,
  input  wire logic [7:0]            fileRdData,
  input  wire logic [7:0]            pcHighLatch,
  output var  logic [6:0]            fileAddr,
  output var  logic [7:0]            fileWrData,
  output var  logic                  fileWrEn,
  output var  logic [7:0]            acc,
  output var  logic                  zeroFlag,
  output var  logic                  zeroWrEn,
  output var  logic [14:0]           pc,
  output var  logic                  flushing
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    byte_op_pkg::exec_state_t st;
    logic [7:0]               acc;
    logic                     zero;
    logic                     zeroWr;
    logic [14:0]              pc;
    logic [6:0]               fAddr;
    logic [7:0]               fData;
    logic                     fWr;
  } state_t;

  state_t s_q;
  state_t s_d;

  decode_if dcd ();

  byte_op_decoder u_dec (
    .instr (instr),
    .dec   (dcd.dec)
  );

  // File address is presented combinationally for the read port;
  // the write-back address is the registered copy.
  logic [7:0] result;
  logic       isZero;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d        = s_q;
    s_d.fWr    = 1'b0;
    s_d.zeroWr = 1'b0;
    result     = 8'h00;
    case (dcd.kind)
      byte_op_pkg::OP_DECSKIP: result = fileRdData - 8'h01;
      byte_op_pkg::OP_INCSKIP,
      byte_op_pkg::OP_INCREMENT_FILE:    result = fileRdData + 8'h01;
      byte_op_pkg::OP_ORWF:    result = s_q.acc | fileRdData;
      byte_op_pkg::OP_ORLIT:   result = s_q.acc | dcd.literal;
      default:                 result = 8'h00;
    endcase
    isZero = (result == 8'h00);
    case (s_q.st)
      byte_op_pkg::ST_EXEC: begin
        s_d.pc = s_q.pc + 15'h0001;
        case (dcd.kind)
          byte_op_pkg::OP_DECSKIP,
          byte_op_pkg::OP_INCSKIP,
          byte_op_pkg::OP_INCREMENT_FILE,
          byte_op_pkg::OP_ORWF: begin
            if (dcd.destFile) begin
              s_d.fWr   = 1'b1;
              s_d.fAddr = dcd.fileAddr;
              s_d.fData = result;
            end else begin
              s_d.acc = result;
            end
            if (dcd.kind == byte_op_pkg::OP_INCREMENT_FILE ||
                dcd.kind == byte_op_pkg::OP_ORWF) begin
              s_d.zero   = isZero;
              s_d.zeroWr = 1'b1;
            end else if (isZero) begin
              s_d.st = byte_op_pkg::ST_FLUSH;
            end
          end
          byte_op_pkg::OP_ORLIT: begin
            s_d.acc    = result;
            s_d.zero   = isZero;
            s_d.zeroWr = 1'b1;
          end
          byte_op_pkg::OP_BRANCH: begin
            s_d.pc = {pcHighLatch[`LATCH_HI:`LATCH_LO], dcd.branchTarget};
            // A skip flush would step past the target word, so a branch
            // waits with pc parked on the target instead
            s_d.st = byte_op_pkg::ST_BR_WAIT;
          end
          default: ;
        endcase
      end
      byte_op_pkg::ST_FLUSH: begin
        // Fetched word is discarded as a no-operation
        s_d.pc = s_q.pc + 15'h0001;
        s_d.st = byte_op_pkg::ST_EXEC;
      end
      byte_op_pkg::ST_BR_WAIT: begin
        // Word at the target is ignored now and executed next cycle
        s_d.st = byte_op_pkg::ST_EXEC;
      end
      default: s_d.st = byte_op_pkg::ST_EXEC;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q <= '{st: byte_op_pkg::ST_EXEC, acc: `ACC_RESET, zero: 1'b0, zeroWr: 1'b0,
               pc: `PC_RESET, fAddr: 7'h00, fData: 8'h00, fWr: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_comb begin
    fileWrData = s_q.fData;
    fileWrEn   = s_q.fWr;
    acc        = s_q.acc;
    zeroFlag   = s_q.zero;
    zeroWrEn   = s_q.zeroWr;
    pc         = s_q.pc;
    flushing   = (s_q.st != byte_op_pkg::ST_EXEC);
    fileAddr   = s_q.fWr ? s_q.fAddr : dcd.fileAddr;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence branchSeen;
    !flushing && dcd.kind == byte_op_pkg::OP_BRANCH;
  endsequence

  // The target address must survive the dead cycle untouched
  sequence branchHeld;
    flushing ##1 (pc == $past(pc));
  endsequence

  a_branch_pc_load: assert property (@(posedge ref_clk) disable iff (rst)
    branchSeen |=> pc[10:0] == $past(instr[10:0]))
    else $error("branch did not load low PC bits");
  a_branch_pc_high: assert property (@(posedge ref_clk) disable iff (rst)
    branchSeen |=> pc[14:11] == $past(pcHighLatch[6:3]))
    else $error("branch did not load high PC bits from latch");
  a_branch_two_cyc: assert property (@(posedge ref_clk) disable iff (rst)
    branchSeen |=> flushing ##1 !flushing)
    else $error("branch not two cycles");
  a_dec_skip_zero: assert property (@(posedge ref_clk) disable iff (rst)
    (!flushing && dcd.kind == byte_op_pkg::OP_DECSKIP && fileRdData == 8'h01) |=> flushing)
    else $error("decrement to zero did not skip");
  a_inc_skip_zero: assert property (@(posedge ref_clk) disable iff (rst)
    (!flushing && dcd.kind == byte_op_pkg::OP_INCSKIP && fileRdData == 8'hff) |=> flushing)
    else $error("increment to zero did not skip");
  a_skip_no_flag: assert property (@(posedge ref_clk) disable iff (rst)
    (!flushing && (dcd.kind == byte_op_pkg::OP_DECSKIP ||
     dcd.kind == byte_op_pkg::OP_INCSKIP)) |=> !zeroWrEn && $stable(zeroFlag))
    else $error("skip instruction touched zero flag");
  a_dest_select: assert property (@(posedge ref_clk) disable iff (rst)
    (!flushing && dcd.kind == byte_op_pkg::OP_INCREMENT_FILE) |=> fileWrEn == $past(instr[7]))
    else $error("destination select wrong");
  a_orlit_zero: assert property (@(posedge ref_clk) disable iff (rst)
    (!flushing && dcd.kind == byte_op_pkg::OP_ORLIT) |=>
      zeroWrEn && zeroFlag == (acc == 8'h00) && acc == ($past(acc) | $past(instr[7:0])))
    else $error("literal OR result or zero flag wrong");
  a_single_cycle: assert property (@(posedge ref_clk) disable iff (rst)
    (!flushing && (dcd.kind == byte_op_pkg::OP_INCREMENT_FILE || dcd.kind == byte_op_pkg::OP_ORWF))
      |=> !flushing && pc == $past(pc) + 15'h0001)
    else $error("single-cycle op stalled");
  a_branch_target: assert property (@(posedge ref_clk) disable iff (rst)
    branchSeen |=> branchHeld)
    else $error("branch target word was not held");
  a_increment_file_result: assert property (@(posedge ref_clk) disable iff (rst)
    (!flushing && dcd.kind == byte_op_pkg::OP_INCREMENT_FILE && !dcd.destFile) |=>
      zeroWrEn && acc == 8'($past(fileRdData) + 8'h01) && zeroFlag == (acc == 8'h00))
    else $error("increment result or zero flag wrong");
  a_orwf_result: assert property (@(posedge ref_clk) disable iff (rst)
    (!flushing && dcd.kind == byte_op_pkg::OP_ORWF && dcd.destFile) |=>
      fileWrEn && zeroWrEn && fileWrData == ($past(acc) | $past(fileRdData)) &&
      zeroFlag == (fileWrData == 8'h00))
    else $error("file OR result or zero flag wrong");
  a_dec_no_skip: assert property (@(posedge ref_clk) disable iff (rst)
    (!flushing && dcd.kind == byte_op_pkg::OP_DECSKIP && fileRdData != 8'h01) |=> !flushing)
    else $error("nonzero decrement skipped");

endmodule : byte_op_branch_exec
`default_nettype wire

// ==== sim/prog_file_model.sv ====
// Program memory and file registers facing the executor
`timescale 1ns/100ps
`default_nettype none
module prog_file_model (
  input  wire logic        ref_clk,
  input  wire logic [14:0] pc,
  output var  logic [13:0] instr,
  input  wire logic [6:0]  fileAddr,
  input  wire logic [7:0]  fileWrData,
  input  wire logic        fileWrEn,
  output var  logic [7:0]  fileRdData
);
  // ----------------------------------------------------------------
  // Storage, loaded by the bench
  // ----------------------------------------------------------------
  logic [13:0] rom [32768];
  logic [7:0]  ram [128];

  assign instr = rom[pc];
  // Read is combinational, so a write-back cycle steers this port too
  assign fileRdData = ram[fileAddr];

  always @(posedge ref_clk) begin
    if (fileWrEn) begin
      ram[fileAddr] <= fileWrData;
    end
  end
endmodule : prog_file_model
`default_nettype wire

// ==== sim/byte_op_branch_exec_bench.sv ====
// Self-checking bench for the instruction subset executor
`timescale 1ns/100ps
`default_nettype none
`include "byte_op_regs.svh"
module byte_op_branch_exec_bench;
  logic        ref_clk;
  logic        rst;
  logic [13:0] instr;
  logic [7:0]  fileRdData;
  logic [7:0]  pcHighLatch;
  logic [6:0]  fileAddr;
  logic [7:0]  fileWrData;
  logic        fileWrEn;
  logic [7:0]  acc;
  logic        zeroFlag;
  logic        zeroWrEn;
  logic [14:0] pc;
  logic        flushing;
  int          nFail;
  int          checksDone;
  localparam logic [14:0] ANY = 15'h7fff;

  byte_op_branch_exec byte_op_branch_exec_inst (.ref_clk(ref_clk), .rst(rst), .instr(instr),
    .fileRdData(fileRdData), .pcHighLatch(pcHighLatch), .fileAddr(fileAddr),
    .fileWrData(fileWrData), .fileWrEn(fileWrEn), .acc(acc), .zeroFlag(zeroFlag),
    .zeroWrEn(zeroWrEn), .pc(pc), .flushing(flushing));
  prog_file_model prog_file_model_inst (.ref_clk(ref_clk), .pc(pc), .instr(instr),
    .fileAddr(fileAddr), .fileWrData(fileWrData), .fileWrEn(fileWrEn),
    .fileRdData(fileRdData));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [13:0] fop(input logic [5:0] o, input logic d, input logic [6:0] f);
    return {o, d, f};
  endfunction : fop

  function automatic logic [13:0] orl(input logic [7:0] k);
    return {`OPC_ORLIT, k};
  endfunction : orl

  task automatic check(input logic [14:0] seen, input logic [14:0] exp);
    checksDone++;
    if (seen !== exp) begin
      nFail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Flags nibble is {zeroFlag, zeroWrEn, fileWrEn, flushing}
  task automatic step(input logic [14:0] p, input logic [7:0] a, input logic [3:0] f);
    @(posedge ref_clk);
    #1;
    if (p !== ANY) check(pc, p);
    check(15'(acc), 15'(a));
    check(15'({zeroFlag, zeroWrEn, fileWrEn, flushing}), 15'(f));
  endtask : step

  task automatic final_report();
    if (nFail == 0 && checksDone > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report

  // ----------------------------------------------------------------
  // Clock, watchdog, tests
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  initial begin
    #5000;
    nFail++;
    final_report();
  end

  initial begin
    rst = 1'b1;
    pcHighLatch = 8'h28;
    nFail = 0;
    checksDone = 0;
    for (int i = 0; i < 32768; i++) prog_file_model_inst.rom[i] = 14'h0;
    prog_file_model_inst.ram[5] = 8'hff;
    prog_file_model_inst.ram[6] = 8'h01;
    prog_file_model_inst.ram[7] = 8'h3c;
    prog_file_model_inst.ram[9] = 8'hff;
    prog_file_model_inst.rom[0] = orl(8'h00);
    prog_file_model_inst.rom[1] = orl(8'h81);
    prog_file_model_inst.rom[2] = fop(`OPC_INCSKIP, 1'b1, 7'h05);
    prog_file_model_inst.rom[3] = orl(8'hff);
    prog_file_model_inst.rom[4] = fop(`OPC_DECSKIP, 1'b0, 7'h06);
    prog_file_model_inst.rom[5] = orl(8'hff);
    prog_file_model_inst.rom[6] = fop(`OPC_ORWF, 1'b0, 7'h07);
    prog_file_model_inst.rom[7] = fop(`OPC_INCREMENT_FILE, 1'b0, 7'h09);
    prog_file_model_inst.rom[8] = fop(`OPC_INCSKIP, 1'b0, 7'h06);
    prog_file_model_inst.rom[9] = fop(`OPC_INCREMENT_FILE, 1'b1, 7'h05);
    prog_file_model_inst.rom[10] = {`OPC_BRANCH, 11'h123};
    prog_file_model_inst.rom[11] = orl(8'hff);
    // Target word must run first; later words write back into file 7
    prog_file_model_inst.rom[15'h2923] = orl(8'h40);
    prog_file_model_inst.rom[15'h2924] = fop(`OPC_ORWF, 1'b1, 7'h07);
    prog_file_model_inst.rom[15'h2925] = orl(8'h00);
    prog_file_model_inst.rom[15'h2926] = fop(`OPC_DECSKIP, 1'b1, 7'h07);
    prog_file_model_inst.rom[15'h2927] = orl(8'h00);
    repeat (6) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    step(15'h1, 8'h00, 4'hc);
    step(15'h2, 8'h81, 4'h4);
    step(15'h3, 8'h81, 4'h3);
    check(15'({fileAddr, fileWrData}), 15'h0500);
    step(15'h4, 8'h81, 4'h0);
    step(15'h5, 8'h00, 4'h1);
    step(15'h6, 8'h00, 4'h0);
    step(15'h7, 8'h3c, 4'h4);
    step(15'h8, 8'h00, 4'hc);
    step(15'h9, 8'h02, 4'h8);
    step(15'ha, 8'h02, 4'h6);
    check(15'({fileAddr, fileWrData}), 15'h0501);
    step(15'h2923, 8'h02, 4'h1);
    step(15'h2923, 8'h02, 4'h0);
    step(15'h2924, 8'h42, 4'h4);
    step(15'h2925, 8'h42, 4'h6);
    check(15'({fileAddr, fileWrData}), 15'h077e);
    step(15'h2926, 8'h42, 4'h4);
    step(15'h2927, 8'h42, 4'h2);
    check(15'({fileAddr, fileWrData}), 15'h077d);
    step(15'h2928, 8'h42, 4'h4);
    check(15'(prog_file_model_inst.ram[5]), 15'h01);
    check(15'(prog_file_model_inst.ram[7]), 15'h7d);
    rst = 1'b1;
    @(posedge ref_clk);
    #1;
    check(pc, 15'h0);
    check(15'(acc), 15'h0);
    final_report();
  end
endmodule : byte_op_branch_exec_bench
`default_nettype wire
